// file: sys_exec_pkg.sv
package sys_exec_pkg;

  // Operation codes handed over by the decode stage
  typedef enum logic [3:0] {
    OP_NOTHING    = 4'h0,
    OP_DATA_BAR   = 4'h1,
    OP_INSTR_BAR  = 4'h2,
    OP_SREG_RD    = 4'h3,
    OP_SREG_WR    = 4'h4,
    OP_SEND_EVT   = 4'h5,
    OP_SUPER_CALL = 4'h6,
    OP_WAIT_EVT   = 4'h7,
    OP_WAIT_INT   = 4'h8
  } op_t;

  // Special register selector codes
  typedef enum logic [7:0] {
    SEL_APP        = 8'h00,
    SEL_INT_APP    = 8'h01,
    SEL_EXE_APP    = 8'h02,
    SEL_COMB       = 8'h03,
    SEL_INT        = 8'h05,
    SEL_EXE        = 8'h06,
    SEL_INT_EXE    = 8'h07,
    SEL_MAIN_SP    = 8'h08,
    SEL_PROC_SP    = 8'h09,
    SEL_PRIO_MASK  = 8'h10,
    SEL_BASE_PRIO  = 8'h11,
    SEL_BASE_COND  = 8'h12,
    SEL_FAULT_MASK = 8'h13,
    SEL_CONTROL    = 8'h14
  } sel_t;

  typedef struct packed {
    op_t         op;
    logic [3:0]  cond;
    sel_t        sel;
    logic [3:0]  rd;
    logic [31:0] src;
  } issue_t;

  typedef struct packed {
    logic        wr;
    logic [3:0]  rd;
    logic [31:0] data;
  } result_t;

  // Status word bit groups
  localparam logic [31:0] APP_MASK = 32'hF800_0000;
  localparam logic [31:0] EXE_MASK = 32'h0700_FC00;
  localparam logic [31:0] EXE_RST = 32'h0100_0000;
  localparam int NZCV_LSB = 28;
  localparam int PRIO_W = 8;

  // Register bus map
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_MASK = 12'h008;
  localparam logic [11:0] ADDR_STATE = 12'h00C;
  localparam int CTRL_PEND_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [4:0] MASK_RST = 5'h00;

  // Sticky event bits
  localparam int STAT_W = 5;
  localparam int STAT_SVC = 0;
  localparam int STAT_SEV = 1;
  localparam int STAT_WAKE = 2;
  localparam int STAT_FLUSH = 3;
  localparam int STAT_DBAR = 4;

  // State register fields
  localparam int STATE_EVT_BIT = 0;
  localparam int STATE_FSM_LSB = 1;
  localparam int STATE_PRIV_BIT = 5;

endpackage

// file: cond_check.sv
`timescale 1ns/1ps
module cond_check (
  // Flags and condition field
  input wire logic [3:0] nzcv_i,
  input wire logic [3:0] cond_i,
  // Verdict
  output logic pass_o
);
  logic n;
  logic z;
  logic c;
  logic v;
  logic base;

  assign {n, z, c, v} = nzcv_i;

  always_comb begin
    unique case (cond_i[3:1])
      3'h0: base = z;
      3'h1: base = c;
      3'h2: base = n;
      3'h3: base = v;
      3'h4: base = c & ~z;
      3'h5: base = (n == v);
      3'h6: base = ~z & (n == v);
      3'h7: base = 1'b1;
    endcase
    // Codes E and F both mean always
    pass_o = (cond_i[0] && cond_i[3:1] != 3'h7) ? ~base : base;
  end
endmodule // cond_check

// file: sync3.sv
`timescale 1ns/1ps
module sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_ni,
  // Asynchronous in, filtered level out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q <= async_i[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // Change counts once two stages agree
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign level_o[i] = lvl_q;
    end
  endgenerate
endmodule // sync3

// file: sys_exec.sv
`timescale 1ns/1ps
// Summary of operation
// - Data barrier stalls later instructions until earlier accesses finish.
// - Instruction barrier flushes the pipeline; later instructions refetch.
// - Barriers, reads, hints, calls and waits leave flags untouched.
// - Each instruction runs only when its condition code passes.
// - Special read returns status views, stack pointers, masks or control.
// - Reading the conditional base-priority selector returns base priority.
// - Unprivileged writes reach only application status; privileged reach all.
// - Unprivileged status writes drop unallocated and execution-state bits.
// - Nonzero conditional base-priority write lowers it or sets it from 0.
// - Special write loads condition flags from source register bits.
// - No-operation has no effect and promises no delay.
// - Send-event pulses all processors and sets the local event register.
// - Supervisor call raises its exception; immediate is ignored.
// - Wait-for-event on clear register sleeps until exception, enabled debug request, event.
// - With send-on-pending set, a newly pending exception also wakes it.
// - Wait-for-event with set register clears it and completes at once.
// - Wait-for-interrupt sleeps until exception or any debug request.
module sys_exec (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Register bus
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic IRQ_O,
  // Instruction issue and completion
  input wire logic ISSUE_VALID_I,
  input wire sys_exec_pkg::issue_t ISSUE_OP_I,
  output logic ISSUE_READY_O,
  output logic DONE_O,
  output sys_exec_pkg::result_t RESULT_O,
  output logic [31:0] APP_STATUS_O,
  // Core side effects
  input wire logic MEM_IDLE_I,
  input wire logic [8:0] EXC_NUM_I,
  input wire logic EXC_WAKE_I,
  input wire logic EXC_PEND_I,
  input wire logic DBG_REQ_I,
  input wire logic DBG_EN_I,
  input wire logic EVENT_I,
  output logic FLUSH_O,
  output logic SVC_REQ_O,
  output logic SEV_OUT_O,
  output logic SLEEP_O
);
  import sys_exec_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_DBAR = 4'b0010,
    S_WEVT = 4'b0100,
    S_WINT = 4'b1000
  } state_t;

  state_t state_q;
  state_t state_d;
  logic rst_s1_q;
  logic rst_n_q;
  logic evt_lvl;
  logic evt_old_q;
  logic evt_rise;
  logic pass;
  logic take;
  logic exec;
  logic priv;
  logic wr;
  logic has_app;
  logic has_exe;
  logic wfe_wake;
  logic wfi_wake;
  logic leave;
  logic ev_q;
  logic done_q;
  logic flush_q;
  logic svc_q;
  logic sev_q;
  logic [31:0] app_q;
  logic [31:0] exe_q;
  logic [31:0] msp_q;
  logic [31:0] psp_q;
  logic pmask_q;
  logic fmask_q;
  logic [1:0] control_q;
  logic [PRIO_W-1:0] base_priority_q;
  logic [PRIO_W-1:0] src_prio;
  logic [31:0] interrupt_status;
  logic [31:0] rd_val;
  result_t result_q;
  logic [31:0] ctrl_q;
  logic [STAT_W-1:0] status_q;
  logic [STAT_W-1:0] mask_q;
  logic [STAT_W-1:0] stat_set;
  logic [31:0] prdata_q;
  logic [31:0] bus_mux;
  logic setup;
  logic access;
  logic hit;
  logic stat_rd;

  // Reset release through two flops
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Event line from another processor is asynchronous
  sync3 #(.W(1)) u_evt_sync (
    .clk_i(CLK_I),
    .rst_ni(rst_n_q),
    .async_i(EVENT_I),
    .level_o(evt_lvl)
  );

  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      evt_old_q <= 1'b0;
    end else begin
      evt_old_q <= evt_lvl;
    end
  end
  assign evt_rise = evt_lvl & ~evt_old_q;

  cond_check u_cond (
    .nzcv_i(app_q[31:NZCV_LSB]),
    .cond_i(ISSUE_OP_I.cond),
    .pass_o(pass)
  );

  assign ISSUE_READY_O = (state_q == S_IDLE);
  assign take = ISSUE_VALID_I & ISSUE_READY_O;
  assign exec = take & pass;
  assign interrupt_status = {23'h0, EXC_NUM_I};
  assign priv = (EXC_NUM_I != 9'h0) | ~control_q[0];
  assign wr = exec & (ISSUE_OP_I.op == OP_SREG_WR);
  assign src_prio = ISSUE_OP_I.src[PRIO_W-1:0];
  assign has_app = ISSUE_OP_I.sel inside
    {SEL_APP, SEL_INT_APP, SEL_EXE_APP, SEL_COMB};
  assign has_exe = ISSUE_OP_I.sel inside
    {SEL_EXE_APP, SEL_COMB, SEL_EXE, SEL_INT_EXE};
  assign wfe_wake = EXC_WAKE_I | (DBG_REQ_I & DBG_EN_I) | evt_rise
    | (ctrl_q[CTRL_PEND_BIT] & EXC_PEND_I);
  assign wfi_wake = EXC_WAKE_I | DBG_REQ_I;

  // Special register read view
  always_comb begin
    unique case (ISSUE_OP_I.sel)
      SEL_APP: rd_val = app_q;
      SEL_INT_APP: rd_val = app_q | interrupt_status;
      SEL_EXE_APP: rd_val = app_q | exe_q;
      SEL_COMB: rd_val = app_q | exe_q | interrupt_status;
      SEL_INT: rd_val = interrupt_status;
      SEL_EXE: rd_val = exe_q;
      SEL_INT_EXE: rd_val = exe_q | interrupt_status;
      SEL_MAIN_SP: rd_val = msp_q;
      SEL_PROC_SP: rd_val = psp_q;
      SEL_PRIO_MASK: rd_val = {31'h0, pmask_q};
      SEL_BASE_PRIO,
      SEL_BASE_COND: rd_val = {24'h0, base_priority_q};
      SEL_FAULT_MASK: rd_val = {31'h0, fmask_q};
      SEL_CONTROL: rd_val = {30'h0, control_q};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Sequencer for stalls and sleeps
  always_comb begin
    state_d = state_q;
    leave = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        if (exec && ISSUE_OP_I.op == OP_DATA_BAR) begin
          state_d = S_DBAR;
        end else if (exec && ISSUE_OP_I.op == OP_WAIT_EVT && !ev_q) begin
          state_d = S_WEVT;
        end else if (exec && ISSUE_OP_I.op == OP_WAIT_INT) begin
          state_d = S_WINT;
        end
      end
      S_DBAR: begin
        if (MEM_IDLE_I) begin
          state_d = S_IDLE;
          leave = 1'b1;
        end
      end
      S_WEVT: begin
        if (wfe_wake) begin
          state_d = S_IDLE;
          leave = 1'b1;
        end
      end
      S_WINT: begin
        if (wfi_wake) begin
          state_d = S_IDLE;
          leave = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end
  assign SLEEP_O = (state_q == S_WEVT) | (state_q == S_WINT);

  // Completion, including failed conditions and no-operation
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      done_q <= 1'b0;
      flush_q <= 1'b0;
      svc_q <= 1'b0;
      sev_q <= 1'b0;
    end else begin
      // Wakeup resumes past the wait, the core takes any exception
      done_q <= leave | (take & (state_d == S_IDLE));
      flush_q <= exec & (ISSUE_OP_I.op == OP_INSTR_BAR);
      svc_q <= exec & (ISSUE_OP_I.op == OP_SUPER_CALL);
      sev_q <= exec & (ISSUE_OP_I.op == OP_SEND_EVT);
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      result_q <= '0;
    end else if (take) begin
      result_q.wr <= exec & (ISSUE_OP_I.op == OP_SREG_RD);
      result_q.rd <= ISSUE_OP_I.rd;
      result_q.data <= rd_val;
    end else begin
      result_q.wr <= 1'b0;
    end
  end

  // Local event register; a new event beats the clear
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ev_q <= 1'b0;
    end else if ((exec && ISSUE_OP_I.op == OP_SEND_EVT)
                 || (evt_rise && state_q != S_WEVT)) begin
      ev_q <= 1'b1;
    end else if (exec && ISSUE_OP_I.op == OP_WAIT_EVT) begin
      ev_q <= 1'b0;
    end
  end

  // Flags change only through a special write
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      app_q <= 32'h0000_0000;
    end else if (wr && has_app) begin
      app_q <= ISSUE_OP_I.src & APP_MASK;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      exe_q <= EXE_RST;
    end else if (wr && has_exe && priv) begin
      exe_q <= ISSUE_OP_I.src & EXE_MASK;
    end
  end

  // Privileged-only registers
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      msp_q <= 32'h0000_0000;
      psp_q <= 32'h0000_0000;
      pmask_q <= 1'b0;
      fmask_q <= 1'b0;
      control_q <= 2'h0;
    end else if (wr && priv) begin
      if (ISSUE_OP_I.sel == SEL_MAIN_SP) begin
        msp_q <= {ISSUE_OP_I.src[31:2], 2'b00};
      end
      if (ISSUE_OP_I.sel == SEL_PROC_SP) begin
        psp_q <= {ISSUE_OP_I.src[31:2], 2'b00};
      end
      if (ISSUE_OP_I.sel == SEL_PRIO_MASK) begin
        pmask_q <= ISSUE_OP_I.src[0];
      end
      if (ISSUE_OP_I.sel == SEL_FAULT_MASK) begin
        fmask_q <= ISSUE_OP_I.src[0];
      end
      if (ISSUE_OP_I.sel == SEL_CONTROL) begin
        control_q <= ISSUE_OP_I.src[1:0];
      end
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      base_priority_q <= '0;
    end else if (wr && priv) begin
      if (ISSUE_OP_I.sel == SEL_BASE_PRIO) begin
        base_priority_q <= src_prio;
      end else if (ISSUE_OP_I.sel == SEL_BASE_COND && src_prio != '0
                   && (base_priority_q == '0 || src_prio < base_priority_q)) begin
        base_priority_q <= src_prio;
      end
    end
  end

  // Register bus; always ready, read data captured in setup
  assign setup = PSEL_I & ~PENABLE_I;
  assign access = PSEL_I & PENABLE_I;
  assign hit = PADDR_I inside {ADDR_CTRL, ADDR_STATUS, ADDR_MASK, ADDR_STATE};
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access & ~hit;
  assign stat_rd = access & ~PWRITE_I & (PADDR_I == ADDR_STATUS);

  always_comb begin
    bus_mux = 32'h0000_0000;
    unique case (PADDR_I)
      ADDR_CTRL: bus_mux = ctrl_q;
      ADDR_STATUS: bus_mux[STAT_W-1:0] = status_q;
      ADDR_MASK: bus_mux[STAT_W-1:0] = mask_q;
      ADDR_STATE: begin
        bus_mux = app_q;
        bus_mux[STATE_EVT_BIT] = ev_q;
        bus_mux[STATE_FSM_LSB +: 4] = state_q;
        bus_mux[STATE_PRIV_BIT] = priv;
      end
      default: bus_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !PWRITE_I) begin
      prdata_q <= bus_mux;
    end
  end
  assign PRDATA_O = prdata_q;

  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
    end else if (access && PWRITE_I) begin
      if (PADDR_I == ADDR_CTRL) begin
        ctrl_q <= {31'h0, PWDATA_I[CTRL_PEND_BIT]};
      end
      if (PADDR_I == ADDR_MASK) begin
        mask_q <= PWDATA_I[STAT_W-1:0];
      end
    end
  end

  // Only bits seen by the read are cleared, so nothing is lost
  assign stat_set = {leave & (state_q == S_DBAR), flush_q,
                     leave & SLEEP_O, sev_q, svc_q};
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~(stat_rd ? prdata_q[STAT_W-1:0] : '0))
                  | stat_set;
    end
  end
  assign IRQ_O = |(status_q & mask_q);

  assign DONE_O = done_q;
  assign RESULT_O = result_q;
  assign APP_STATUS_O = app_q;
  assign FLUSH_O = flush_q;
  assign SVC_REQ_O = svc_q;
  assign SEV_OUT_O = sev_q;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n_q);

  property p_dbar_hold;
    (state_q == S_DBAR && !MEM_IDLE_I) |=> !DONE_O && !ISSUE_READY_O;
  endproperty
  a_dbar_hold: assert property (p_dbar_hold)
    else $error("barrier released before memory idle");

  property p_flush;
    (exec && ISSUE_OP_I.op == OP_INSTR_BAR) |=> FLUSH_O && DONE_O;
  endproperty
  a_flush: assert property (p_flush)
    else $error("instruction barrier did not flush");

  property p_flags_keep;
    (take && ISSUE_OP_I.op != OP_SREG_WR) |=> $stable(app_q);
  endproperty
  a_flags_keep: assert property (p_flags_keep)
    else $error("flags changed by non-write instruction");

  property p_cond_fail;
    (take && !pass) |=> DONE_O && !FLUSH_O && !SVC_REQ_O && !SEV_OUT_O
      && !RESULT_O.wr && $stable(app_q);
  endproperty
  a_cond_fail: assert property (p_cond_fail)
    else $error("failed condition had an effect");

  property p_read_cond;
    (exec && ISSUE_OP_I.op == OP_SREG_RD && ISSUE_OP_I.sel == SEL_BASE_COND)
      |=> RESULT_O.wr && RESULT_O.data == {24'h0, $past(base_priority_q)};
  endproperty
  a_read_cond: assert property (p_read_cond)
    else $error("alias read wrong");

  property p_unpriv;
    (wr && !priv && !has_app) |=> $stable(msp_q) && $stable(base_priority_q)
      && $stable(control_q);
  endproperty
  a_unpriv: assert property (p_unpriv)
    else $error("unprivileged write reached a protected register");

  property p_unpriv_exe;
    (wr && !priv) |=> $stable(exe_q);
  endproperty
  a_unpriv_exe: assert property (p_unpriv_exe)
    else $error("unprivileged write changed execution bits");

  property p_base_zero;
    (wr && ISSUE_OP_I.sel == SEL_BASE_COND && src_prio == '0)
      |=> $stable(base_priority_q);
  endproperty
  a_base_zero: assert property (p_base_zero)
    else $error("zero source changed base priority");

  property p_flags_load;
    (wr && ISSUE_OP_I.sel == SEL_APP)
      |=> app_q == ($past(ISSUE_OP_I.src) & APP_MASK);
  endproperty
  a_flags_load: assert property (p_flags_load)
    else $error("flags not loaded from source");

  property p_send;
    (exec && ISSUE_OP_I.op == OP_SEND_EVT) |=> ev_q && SEV_OUT_O;
  endproperty
  a_send: assert property (p_send)
    else $error("send-event missing");

  property p_wfe_fast;
    (exec && ISSUE_OP_I.op == OP_WAIT_EVT && ev_q)
      |=> DONE_O && ISSUE_READY_O;
  endproperty
  a_wfe_fast: assert property (p_wfe_fast)
    else $error("wait with event set did not complete");

  property p_pend_wake;
    (state_q == S_WEVT && ctrl_q[CTRL_PEND_BIT] && EXC_PEND_I)
      |=> DONE_O ##1 !SLEEP_O;
  endproperty
  a_pend_wake: assert property (p_pend_wake)
    else $error("pending exception did not wake");

  property p_wfi_wake;
    (state_q == S_WINT && DBG_REQ_I) |=> DONE_O && state_q == S_IDLE;
  endproperty
  a_wfi_wake: assert property (p_wfi_wake)
    else $error("debug request did not wake");

  c_wfe_sleep: cover property (state_q == S_WEVT ##[1:20] DONE_O);
  c_dbar: cover property (state_q == S_DBAR ##1 state_q == S_DBAR);
  c_irq: cover property (IRQ_O ##1 stat_rd);
endmodule // sys_exec

// file: test_sys_exec.sv
`timescale 1ns/1ps
module test_sys_exec;
  import sys_exec_pkg::*;
  logic CLK_I, NRST_I, PSEL_I, PENABLE_I, PWRITE_I;
  logic [11:0] PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O, APP_STATUS_O;
  logic PREADY_O, PSLVERR_O, IRQ_O, ISSUE_VALID_I, ISSUE_READY_O, DONE_O;
  issue_t ISSUE_OP_I;
  result_t RESULT_O;
  logic MEM_IDLE_I, EXC_WAKE_I, EXC_PEND_I, DBG_REQ_I, DBG_EN_I, EVENT_I;
  logic [8:0] EXC_NUM_I;
  logic FLUSH_O, SVC_REQ_O, SEV_OUT_O, SLEEP_O;
  logic [4:0] pins;
  int mismatches, samples_checked, done_cnt, want;
  int flush_cnt, svc_cnt, sev_cnt, sleep_cnt, seed;
  result_t exp_q[$];
  logic [31:0] rdat, flags, v;
  logic err;
  logic [3:0] c_code [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hE};
  logic c_pass [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [7:0] b_src [6] = '{8'h40, 8'h60, 8'h20, 8'h00, 8'h00, 8'h50};
  logic [7:0] b_exp [6] = '{8'h40, 8'h40, 8'h20, 8'h20, 8'h00, 8'h50};
  logic b_cond [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  assign {EVENT_I, EXC_WAKE_I, EXC_PEND_I, DBG_REQ_I, DBG_EN_I} = pins;

  sys_exec u_sys_exec (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O), .ISSUE_VALID_I(ISSUE_VALID_I),
    .ISSUE_OP_I(ISSUE_OP_I), .ISSUE_READY_O(ISSUE_READY_O),
    .DONE_O(DONE_O), .RESULT_O(RESULT_O), .APP_STATUS_O(APP_STATUS_O),
    .MEM_IDLE_I(MEM_IDLE_I), .EXC_NUM_I(EXC_NUM_I),
    .EXC_WAKE_I(EXC_WAKE_I), .EXC_PEND_I(EXC_PEND_I),
    .DBG_REQ_I(DBG_REQ_I), .DBG_EN_I(DBG_EN_I), .EVENT_I(EVENT_I),
    .FLUSH_O(FLUSH_O), .SVC_REQ_O(SVC_REQ_O), .SEV_OUT_O(SEV_OUT_O),
    .SLEEP_O(SLEEP_O)
  );

  initial begin
    CLK_I = 1'b0;
    forever #25 CLK_I = ~CLK_I;
  end

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  task automatic chk_res(input result_t got, input result_t exp);
    samples_checked++;
    if (got.wr !== exp.wr || (exp.wr && got !== exp)) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pulses stand one cycle, so the falling edge sees each of them once
  always @(negedge CLK_I) begin
    if (FLUSH_O === 1'b1) flush_cnt++;
    if (SVC_REQ_O === 1'b1) svc_cnt++;
    if (SEV_OUT_O === 1'b1) sev_cnt++;
    if (SLEEP_O === 1'b1) sleep_cnt++;
    if (DONE_O === 1'b1) begin
      if (exp_q.size() == 0)
        chk32(32'h1, 32'h0);
      else
        chk_res(RESULT_O, exp_q.pop_front());
      done_cnt++;
    end
  end

  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge CLK_I);
    PSEL_I <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    do @(posedge CLK_I); while (PREADY_O !== 1'b1);
    rdat = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk32(rdat & m, e);
  endtask

  task automatic issue_go(input op_t op, input logic [3:0] c,
      input sel_t s, input logic [31:0] d_in, input logic w,
      input logic [31:0] d);
    logic [3:0] rd;
    // Stack pointer and program counter never named as destination
    rd = 4'($unsigned($random(seed)) % 13);
    exp_q.push_back('{w, rd, d});
    want++;
    @(posedge CLK_I);
    ISSUE_VALID_I <= 1'b1;
    ISSUE_OP_I <= '{op, c, s, rd, d_in};
    do @(negedge CLK_I); while (ISSUE_READY_O !== 1'b1);
    @(posedge CLK_I);
    ISSUE_VALID_I <= 1'b0;
  endtask

  task automatic wait_done();
    int t;
    t = 0;
    while (done_cnt < want && t < 300) begin
      @(posedge CLK_I);
      t++;
    end
    chk1(done_cnt >= want, 1'b1);
    repeat (2) @(posedge CLK_I);
  endtask

  task automatic run(input op_t op, input logic [3:0] c, input sel_t s,
      input logic [31:0] d_in, input logic w, input logic [31:0] d);
    issue_go(op, c, s, d_in, w, d);
    wait_done();
  endtask

  // First pin set must leave the core asleep, second must wake it
  task automatic wake(input op_t op, input logic [4:0] no,
      input logic [4:0] yes);
    issue_go(op, 4'hE, SEL_APP, 32'h0, 1'b0, 32'h0);
    pins <= no;
    repeat (8) @(posedge CLK_I);
    chk1(SLEEP_O, 1'b1);
    chk1(done_cnt < want, 1'b1);
    pins <= yes;
    repeat (6) @(posedge CLK_I);
    pins <= 5'h00;
    wait_done();
    chk1(SLEEP_O, 1'b0);
    chk1(ISSUE_READY_O, 1'b1);
  endtask

  initial begin
    #(50 * 20000);
    mismatches++;
    report_and_stop();
  end

  initial begin
    seed = 39;
    {NRST_I, PSEL_I, PENABLE_I, PWRITE_I, ISSUE_VALID_I} = 5'h00;
    {PADDR_I, PWDATA_I, ISSUE_OP_I, EXC_NUM_I, pins} = '0;
    MEM_IDLE_I = 1'b1;
    repeat (6) @(posedge CLK_I);
    NRST_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    rchk(ADDR_CTRL, 32'hFFFF_FFFF, CTRL_RST);
    rchk(ADDR_MASK, 32'hFFFF_FFFF, {27'h0, MASK_RST});
    rchk(ADDR_STATUS, 32'hFFFF_FFFF, 32'h0);
    rchk(ADDR_STATE, 32'hF800_003F, 32'h0000_0022);
    rchk(12'h010, 32'hFFFF_FFFF, 32'h0);
    chk1(err, 1'b1);
    $display("test reset and map done");
    flags = ($random(seed) & 32'hD800_0000) | 32'h4000_0000;
    v = flags | ($random(seed) & ~APP_MASK);
    run(OP_SREG_WR, 4'hE, SEL_APP, v, 1'b0, 32'h0);
    chk32(APP_STATUS_O, flags);
    for (int i = 0; i < 5; i++)
      run(OP_SREG_RD, c_code[i], SEL_APP, 32'h0, c_pass[i], flags);
    run(OP_SEND_EVT, 4'h1, SEL_APP, 32'h0, 1'b0, 32'h0);
    chk32(sev_cnt, 0);
    $display("test flags and conditions done");
    for (int i = 0; i < 6; i++) begin
      run(OP_SREG_WR, 4'hE, b_cond[i] ? SEL_BASE_COND : SEL_BASE_PRIO,
          {24'h0, b_src[i]}, 1'b0, 32'h0);
      run(OP_SREG_RD, 4'hE, i[0] ? SEL_BASE_COND : SEL_BASE_PRIO,
          32'h0, 1'b1, {24'h0, b_exp[i]});
    end
    for (int i = 0; i < 2; i++) begin
      v = $random(seed);
      run(OP_SREG_WR, 4'hE, i ? SEL_PROC_SP : SEL_MAIN_SP, v, 1'b0, 32'h0);
      run(OP_SREG_RD, 4'hE, i ? SEL_PROC_SP : SEL_MAIN_SP, 32'h0, 1'b1,
          v & 32'hFFFF_FFFC);
    end
    EXC_NUM_I <= 9'h0A5;
    run(OP_SREG_WR, 4'hE, SEL_PRIO_MASK, 32'h3, 1'b0, 32'h0);
    run(OP_SREG_WR, 4'hE, SEL_FAULT_MASK, 32'h1, 1'b0, 32'h0);
    run(OP_SREG_RD, 4'hE, SEL_PRIO_MASK, 32'h0, 1'b1, 32'h1);
    run(OP_SREG_RD, 4'hE, SEL_FAULT_MASK, 32'h0, 1'b1, 32'h1);
    run(OP_SREG_RD, 4'hE, SEL_INT, 32'h0, 1'b1, 32'h0A5);
    run(OP_SREG_RD, 4'hE, SEL_EXE, 32'h0, 1'b1, EXE_RST);
    run(OP_SREG_RD, 4'hE, SEL_INT_EXE, 32'h0, 1'b1, EXE_RST | 32'hA5);
    run(OP_SREG_RD, 4'hE, SEL_INT_APP, 32'h0, 1'b1, flags | 32'hA5);
    run(OP_SREG_RD, 4'hE, SEL_EXE_APP, 32'h0, 1'b1, flags | EXE_RST);
    EXC_NUM_I <= 9'h000;
    $display("test privileged moves done");
    run(OP_SREG_WR, 4'hE, SEL_CONTROL, 32'h1, 1'b0, 32'h0);
    rchk(ADDR_STATE, 32'h20, 32'h0);
    run(OP_SREG_RD, 4'hE, SEL_CONTROL, 32'h0, 1'b1, 32'h1);
    run(OP_SREG_WR, 4'hE, SEL_BASE_PRIO, 32'h10, 1'b0, 32'h0);
    run(OP_SREG_RD, 4'hE, SEL_BASE_PRIO, 32'h0, 1'b1, 32'h50);
    run(OP_SREG_WR, 4'hE, SEL_COMB, 32'hFFFF_FFFF, 1'b0, 32'h0);
    flags = APP_MASK;
    chk32(APP_STATUS_O, flags);
    run(OP_SREG_RD, 4'hE, SEL_COMB, 32'h0, 1'b1, APP_MASK | EXE_RST);
    EXC_NUM_I <= 9'h00B;
    run(OP_SREG_WR, 4'hE, SEL_CONTROL, 32'h0, 1'b0, 32'h0);
    EXC_NUM_I <= 9'h000;
    $display("test unprivileged moves done");
    apb(1'b0, ADDR_STATUS, 32'h0);
    apb(1'b1, ADDR_MASK, 32'h0000_001F);
    run(OP_SEND_EVT, 4'hE, SEL_APP, 32'h0, 1'b0, 32'h0);
    chk32(sev_cnt, 1);
    chk1(IRQ_O, 1'b1);
    rchk(ADDR_STATE, 32'h1, 32'h1);
    rchk(ADDR_STATUS, 32'h2, 32'h2);
    @(posedge CLK_I);
    chk1(IRQ_O, 1'b0);
    v = sleep_cnt;
    run(OP_WAIT_EVT, 4'hE, SEL_APP, 32'h0, 1'b0, 32'h0);
    chk32(sleep_cnt, v);
    rchk(ADDR_STATE, 32'h1, 32'h0);
    wake(OP_WAIT_EVT, 5'b00010, 5'b10000);
    rchk(ADDR_STATE, 32'h1, 32'h0);
    wake(OP_WAIT_EVT, 5'b00100, 5'b01000);
    wake(OP_WAIT_EVT, 5'b00000, 5'b00011);
    apb(1'b1, ADDR_CTRL, 32'h1);
    wake(OP_WAIT_EVT, 5'b00000, 5'b00100);
    apb(1'b1, ADDR_CTRL, 32'h0);
    wake(OP_WAIT_INT, 5'b00100, 5'b00010);
    wake(OP_WAIT_INT, 5'b00000, 5'b01000);
    $display("test events and sleep done");
    apb(1'b0, ADDR_STATUS, 32'h0);
    apb(1'b1, ADDR_MASK, 32'h0);
    MEM_IDLE_I <= 1'b0;
    issue_go(OP_DATA_BAR, 4'hE, SEL_APP, 32'h0, 1'b0, 32'h0);
    repeat (6) @(posedge CLK_I);
    chk1(done_cnt < want, 1'b1);
    chk1(ISSUE_READY_O, 1'b0);
    MEM_IDLE_I <= 1'b1;
    wait_done();
    run(OP_INSTR_BAR, 4'hE, SEL_APP, 32'h0, 1'b0, 32'h0);
    run(OP_INSTR_BAR, 4'h1, SEL_APP, 32'h0, 1'b0, 32'h0);
    chk32(flush_cnt, 1);
    run(OP_SUPER_CALL, 4'hE, SEL_APP, $random(seed) & 32'hFF, 1'b0, 32'h0);
    chk32(svc_cnt, 1);
    run(OP_NOTHING, 4'hE, SEL_APP, $random(seed), 1'b0, 32'h0);
    chk32(flush_cnt + svc_cnt + sev_cnt, 3);
    chk1(IRQ_O, 1'b0);
    rchk(ADDR_STATUS, 32'h19, 32'h19);
    rchk(ADDR_STATUS, 32'h19, 32'h0);
    chk32(APP_STATUS_O, flags);
    $display("test barriers and calls done");
    report_and_stop();
  end
endmodule // test_sys_exec
